// ---- hdl/pif_pkg.sv ----
// package: register map, field layout and carrier types of the peripheral irq flag block
package pif_pkg;

  localparam logic [11:0] PIF_OFS_DMA_ADC      = 12'h4b0;
  localparam logic [11:0] PIF_OFS_TIMER_SERIAL = 12'h4b1;
  localparam logic [11:0] PIF_OFS_PWM_UART     = 12'h4b2;
  localparam logic [11:0] PIF_OFS_STATUS       = 12'h4b3;
  localparam logic [11:0] PIF_OFS_MASK         = 12'h4b4;
  localparam int          PIF_ADDR_W           = 14;

  localparam logic [7:0]  PIF_FLAG_RESET  = 8'h00;
  localparam logic [7:0]  PIF_MASK_RESET  = 8'h00;
  localparam logic [31:0] PIF_RDATA_ZERO  = 32'h0000_0000;

  // hardware-set, software-cleared bits per register; all else read-only or unimplemented
  localparam logic [7:0]  PIF_SW_DMA_ADC      = 8'hf1;
  localparam logic [7:0]  PIF_IMPL_DMA_ADC    = 8'hf1;
  localparam logic [7:0]  PIF_SW_TIMER_SERIAL = 8'hf8;
  localparam logic [7:0]  PIF_SW_PWM_UART     = 8'h40;
  localparam logic [7:0]  PIF_IMPL_PWM_UART   = 8'hcf;

  localparam logic [1:0]  PIF_HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0]  PIF_HSIZE_WORD    = 3'b010;

  // status bits: one per register, set when any flag in it rises
  localparam int PIF_STAT_W = 3;

  typedef struct packed {
    logic dma_ch1_abort_flag;
    logic dma_ch1_overrun_flag;
    logic dma_ch1_dest_count_flag;
    logic dma_ch1_src_count_flag;
    logic adc_threshold_flag;
    logic timer_zero_flag;
    logic capcomp_one_flag;
    logic timer_one_gate_flag;
    logic timer_one_flag;
    logic timer_two_flag;
    logic pwm_one_period_flag;
  } pif_events_t;

  typedef struct packed {
    logic [7:0] serport1_int_flag_reg;
    logic       serport1_tx_flag;
    logic       serport1_rx_flag;
    logic [7:0] pwm_one_general_int_reg;
    logic [7:0] uart_one_int_reg;
    logic [7:0] uart_one_error_reg;
    logic       uart_one_tx_flag;
    logic       uart_one_rx_flag;
  } pif_periph_state_t;

  typedef struct packed {
    logic [1:0]            htrans;
    logic [PIF_ADDR_W-1:0] haddr;
    logic                  hwrite;
    logic [2:0]            hsize;
    logic                  hsel;
    logic                  hready;
    logic [31:0]           hwdata;
  } pif_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } pif_ahb_rsp_t;

  // sel fields decode a write in its data phase, rsel a read in its address phase:
  // rsel holds {mask, status, flag register 2..0}
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] sel;
    logic       sel_stat;
    logic       sel_mask;
    logic [4:0] rsel;
    logic [7:0] wdata;
  } pif_reg_acc_t;

endpackage : pif_pkg

// ---- hdl/pif_ahb_slave.sv ----
// ahb-lite slave front end: address phase capture and single-cycle access strobes
`timescale 1ns/1ps
module pif_ahb_slave (
  input  wire logic                 clk_sys_i,
  input  wire logic                 reset_n_i,
  input  wire pif_pkg::pif_ahb_req_t ahb_i,
  output pif_pkg::pif_reg_acc_t     acc_o
);
  import pif_pkg::*;

  typedef struct packed {
    logic                  pend_wr;
    logic                  pend_rd;
    logic [PIF_ADDR_W-1:0] addr;
  } pif_slv_state_t;

  pif_slv_state_t st_r;
  pif_slv_state_t st_nxt;
  logic           take;

  function automatic logic hit(input logic [PIF_ADDR_W-1:0] a, input logic [11:0] ofs);
    hit = (a == {ofs, 2'b00});
  endfunction : hit

  assign take = ahb_i.hsel && ahb_i.hready && (ahb_i.htrans == PIF_HTRANS_NONSEQ);

  always_comb begin
    st_nxt         = st_r;
    st_nxt.pend_wr = take && ahb_i.hwrite;
    st_nxt.pend_rd = take && !ahb_i.hwrite;
    if (take) begin
      st_nxt.addr = ahb_i.haddr;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // writes decode the held address in the data phase, when hwdata stands; reads decode
  // the live address, so a read right behind a write keeps both decodes apart
  always_comb begin
    acc_o.wr       = st_r.pend_wr;
    acc_o.rd       = take && !ahb_i.hwrite;
    acc_o.wdata    = ahb_i.hwdata[7:0];
    acc_o.sel[0]   = hit(st_r.addr, PIF_OFS_DMA_ADC);
    acc_o.sel[1]   = hit(st_r.addr, PIF_OFS_TIMER_SERIAL);
    acc_o.sel[2]   = hit(st_r.addr, PIF_OFS_PWM_UART);
    acc_o.sel_stat = hit(st_r.addr, PIF_OFS_STATUS);
    acc_o.sel_mask = hit(st_r.addr, PIF_OFS_MASK);
    acc_o.rsel[0]  = hit(ahb_i.haddr, PIF_OFS_DMA_ADC);
    acc_o.rsel[1]  = hit(ahb_i.haddr, PIF_OFS_TIMER_SERIAL);
    acc_o.rsel[2]  = hit(ahb_i.haddr, PIF_OFS_PWM_UART);
    acc_o.rsel[3]  = hit(ahb_i.haddr, PIF_OFS_STATUS);
    acc_o.rsel[4]  = hit(ahb_i.haddr, PIF_OFS_MASK);
  end

endmodule : pif_ahb_slave

// ---- hdl/pif_flag_bank.sv ----
// one 8-bit flag register: hardware sets, software writes 0 to clear, read-only bits mirrored
`timescale 1ns/1ps
module pif_flag_bank (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_n_i,
  input  wire logic [7:0] sw_mask_i,
  input  wire logic [7:0] set_i,
  input  wire logic [7:0] ro_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] flags_o,
  output logic      [7:0] rise_o
);
  import pif_pkg::*;

  typedef struct packed {
    logic [7:0] sw;
    logic [7:0] view;
  } pif_bank_state_t;

  pif_bank_state_t st_r;
  pif_bank_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    // a write may only clear; a set in the same cycle wins
    if (wr_i) begin
      st_nxt.sw = st_r.sw & wdata_i;  // see [R3]
    end
    st_nxt.sw   = (st_nxt.sw | set_i) & sw_mask_i;  // see [R1]
    st_nxt.view = st_nxt.sw | (ro_i & ~sw_mask_i);  // see [R5]
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= {PIF_FLAG_RESET, PIF_FLAG_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flags_o = st_r.view;
  assign rise_o  = st_nxt.view & ~st_r.view;

endmodule : pif_flag_bank

// ---- hdl/pif_irq_flags.sv ----
// top: three peripheral irq flag registers behind an ahb-lite slave, with summary interrupt
// Overview of operation
// [R1] flags set on event regardless of enables
// [R2] software clears flag before enabling interrupt
// [R3] hw sets to 1, software writes 0
// [R4] serport1 summary: OR of its flag register
// [R5] serport1 tx/rx read-only, mirror peripheral
// [R6] pwm1 parameter flag: OR of general register
// [R7] uart1 general flag: OR of its register
// [R8] uart1 framing flag: OR of error register
// [R9] uart1 tx/rx read-only, follow buffer state
// [R10] first register: dma1 7..4, adc 0
// [R11] second register: timers, capcomp, serport1 layout
// [R12] third register: pwm1 7..6, uart1 3..0
// [R13] unimplemented bits read zero, writes ignored
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/1ps
module pif_irq_flags (
  input  wire logic                      clk_sys_i,
  input  wire logic                      reset_n_i,
  input  wire pif_pkg::pif_ahb_req_t     ahb_i,
  output pif_pkg::pif_ahb_rsp_t          ahb_o,
  input  wire pif_pkg::pif_events_t      events_i,
  input  wire pif_pkg::pif_periph_state_t periph_i,
  output logic                           irq_o,
  output logic [7:0]                     irq_flags_dma_adc_o,
  output logic [7:0]                     irq_flags_timer_serial_o,
  output logic [7:0]                     irq_flags_pwm_uart_o
);
  import pif_pkg::*;

  typedef struct packed {
    logic [PIF_STAT_W-1:0] status;
    logic [PIF_STAT_W-1:0] mask;
    logic [31:0]           rdata;
  } pif_top_state_t;

  pif_top_state_t st_r;
  pif_top_state_t st_nxt;
  pif_reg_acc_t   acc;
  logic [7:0]     set0, set1, set2;
  logic [7:0]     ro0, ro1, ro2;
  logic [7:0]     flg0, flg1, flg2;
  logic [7:0]     rise0, rise1, rise2;
  logic [PIF_STAT_W-1:0] ev_any;

  pif_ahb_slave u_slave (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .ahb_i     (ahb_i),
    .acc_o     (acc)
  );

  // bit layout of the three flag registers
  always_comb begin
    set0 = {events_i.dma_ch1_abort_flag, events_i.dma_ch1_overrun_flag,
            events_i.dma_ch1_dest_count_flag, events_i.dma_ch1_src_count_flag,
            3'b000, events_i.adc_threshold_flag};  // see [R10]
    ro0  = 8'h00;
    set1 = {events_i.timer_zero_flag, events_i.capcomp_one_flag,
            events_i.timer_one_gate_flag, events_i.timer_one_flag,
            events_i.timer_two_flag, 3'b000};  // see [R11]
    ro1  = {5'b00000, |periph_i.serport1_int_flag_reg,  // see [R4]
            periph_i.serport1_tx_flag, periph_i.serport1_rx_flag};  // see [R5]
    set2 = {1'b0, events_i.pwm_one_period_flag, 6'b000000};  // see [R12]
    ro2  = {|periph_i.pwm_one_general_int_reg, 3'b000,  // see [R6]
            |periph_i.uart_one_int_reg,  // see [R7]
            |periph_i.uart_one_error_reg,  // see [R8]
            periph_i.uart_one_tx_flag, periph_i.uart_one_rx_flag};  // see [R9]
  end

  pif_flag_bank u_bank0 (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .sw_mask_i (PIF_SW_DMA_ADC),
    .set_i     (set0),
    .ro_i      (ro0),
    .wr_i      (acc.wr && acc.sel[0]),
    .wdata_i   (acc.wdata & PIF_IMPL_DMA_ADC),  // see [R13]
    .flags_o   (flg0),
    .rise_o    (rise0)
  );

  pif_flag_bank u_bank1 (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .sw_mask_i (PIF_SW_TIMER_SERIAL),
    .set_i     (set1),
    .ro_i      (ro1),
    .wr_i      (acc.wr && acc.sel[1]),
    .wdata_i   (acc.wdata),
    .flags_o   (flg1),
    .rise_o    (rise1)
  );

  pif_flag_bank u_bank2 (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .sw_mask_i (PIF_SW_PWM_UART),
    .set_i     (set2),
    .ro_i      (ro2),
    .wr_i      (acc.wr && acc.sel[2]),
    .wdata_i   (acc.wdata & PIF_IMPL_PWM_UART),  // see [R13]
    .flags_o   (flg2),
    .rise_o    (rise2)
  );

  assign ev_any = {|rise2, |rise1, |rise0};

  always_comb begin
    st_nxt = st_r;
    if (acc.wr && acc.sel_mask) begin
      st_nxt.mask = acc.wdata[PIF_STAT_W-1:0];
    end
    if (acc.rd && acc.rsel[3]) begin
      st_nxt.status = '0;
    end
    st_nxt.status = st_nxt.status | ev_any;
    if (acc.rd) begin
      unique case (1'b1)
        acc.rsel[0]: st_nxt.rdata = {24'h000000, flg0};
        acc.rsel[1]: st_nxt.rdata = {24'h000000, flg1};
        acc.rsel[2]: st_nxt.rdata = {24'h000000, flg2};
        acc.rsel[3]: st_nxt.rdata = {29'h0, st_r.status};
        acc.rsel[4]: st_nxt.rdata = {29'h0, st_r.mask};
        default:     st_nxt.rdata = PIF_RDATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ahb_o.hrdata    = st_r.rdata;
  assign ahb_o.hreadyout = 1'b1;
  assign ahb_o.hresp     = 1'b0;
  assign irq_o           = |(st_r.status & st_r.mask);
  assign irq_flags_dma_adc_o      = flg0;
  assign irq_flags_timer_serial_o = flg1;
  assign irq_flags_pwm_uart_o     = flg2;

  a_flag_set_event: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    events_i.timer_zero_flag |=> flg1[7]) else $error("timer zero event not latched"); // see [R1]
  a_flag_holds: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    flg0[7] && !(acc.wr && acc.sel[0]) |=> flg0[7]) else $error("abort flag dropped"); // see [R3]
  a_flag_clear: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    acc.wr && acc.sel[1] && !acc.wdata[3] && !events_i.timer_two_flag |=> !flg1[3])
    else $error("timer two flag not cleared"); // see [R3]
  a_serport_sum: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    ##1 flg1[2] == $past(|periph_i.serport1_int_flag_reg))
    else $error("serport summary mismatch"); // see [R4]
  a_serport_rx: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    ##1 flg1[0] == $past(periph_i.serport1_rx_flag)) else $error("serport rx mismatch"); // see [R5]
  a_pwm_param: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    ##1 flg2[7] == $past(|periph_i.pwm_one_general_int_reg))
    else $error("pwm param mismatch"); // see [R6]
  a_uart_general: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    ##1 flg2[3] == $past(|periph_i.uart_one_int_reg)) else $error("uart general mismatch"); // see [R7]
  a_uart_framing: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    ##1 flg2[2] == $past(|periph_i.uart_one_error_reg)) else $error("uart framing mismatch"); // see [R8]
  a_uart_txrx: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    ##1 flg2[1:0] == $past({periph_i.uart_one_tx_flag, periph_i.uart_one_rx_flag}))
    else $error("uart tx rx mismatch"); // see [R9]
  a_unimpl_zero: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    flg0[3:1] == 3'b000 && flg2[5:4] == 2'b00) else $error("unimplemented bit set"); // see [R13]
  a_set_wins_clear: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see [R3]
    events_i.timer_two_flag && acc.wr && acc.sel[1] && !acc.wdata[3] |=> flg1[3])
    else $error("event lost against clearing write");
  a_serport_tx: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see [R5]
    ##1 flg1[1] == $past(periph_i.serport1_tx_flag)) else $error("serport tx mismatch");
  a_status_sticky: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i) // see [R1]
    ev_any[0] |=> st_r.status[0]) else $error("status bit lost on flag rise");

endmodule : pif_irq_flags

// ---- test/pif_periph_model.sv ----
// peripheral model: registers event pulses and state levels toward the flag block
`timescale 1ns/1ps
module pif_periph_model (
  input  wire logic                        clk_sys_i,
  input  wire logic                        reset_n_i,
  input  wire pif_pkg::pif_events_t        ev_cmd_i,
  input  wire pif_pkg::pif_periph_state_t  st_cmd_i,
  output pif_pkg::pif_events_t             events_o,
  output pif_pkg::pif_periph_state_t       periph_o
);
  import pif_pkg::*;
  // events are one-cycle pulses, state levels hold until the peripheral changes them
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      events_o <= '0;
      periph_o <= '0;
    end else begin
      events_o <= ev_cmd_i;
      periph_o <= st_cmd_i;
    end
  end
endmodule : pif_periph_model

// ---- test/tb_peripheral_irq_flag_regs.sv ----
// testbench: register access, event flags, read-only mirrors and interrupt of the flag block
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_peripheral_irq_flag_regs;
  import pif_pkg::*;
  localparam logic [13:0] A_STAT = {PIF_OFS_STATUS, 2'b00};
  localparam logic [13:0] A_MASK = {PIF_OFS_MASK, 2'b00};
  logic              clk_sys_i = 1'b0;
  logic              reset_n_i = 1'b0;
  pif_ahb_req_t      req       = '0;
  pif_ahb_req_t      bus;
  pif_ahb_rsp_t      rsp;
  pif_events_t       ev_cmd    = '0;
  pif_events_t       events;
  pif_periph_state_t st_cmd    = '0;
  pif_periph_state_t periph;
  logic              irq_o;
  wire [7:0]         flo[3];
  logic [31:0]       exp_q[$];
  logic [31:0]       e_v;
  logic              dp_rd     = 1'b0;
  int                n_errors  = 0;
  int                n_tests   = 0;
  int                cyc       = 0;
  logic [13:0]       adr[3]    = '{{PIF_OFS_DMA_ADC, 2'b00}, {PIF_OFS_TIMER_SERIAL, 2'b00},
                                   {PIF_OFS_PWM_UART, 2'b00}};
  logic [7:0]        sw[3]     = '{PIF_SW_DMA_ADC, PIF_SW_TIMER_SERIAL, PIF_SW_PWM_UART};
  int                rg[11]    = '{2, 1, 1, 1, 1, 1, 0, 0, 0, 0, 0};
  int                bt[11]    = '{6, 3, 4, 5, 6, 7, 0, 4, 5, 6, 7};

  pif_periph_model i_pif_periph_model (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .ev_cmd_i(ev_cmd), .st_cmd_i(st_cmd), .events_o(events), .periph_o(periph));
  pif_irq_flags i_pif_irq_flags (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ahb_i(bus),
    .ahb_o(rsp), .events_i(events), .periph_i(periph), .irq_o(irq_o),
    .irq_flags_dma_adc_o(flo[0]), .irq_flags_timer_serial_o(flo[1]),
    .irq_flags_pwm_uart_o(flo[2]));

  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  always_comb begin
    bus        = req;
    bus.hready = rsp.hreadyout;
  end

  // read data is compared at the edge that ends its data phase
  always @(posedge clk_sys_i) begin
    if (dp_rd && rsp.hreadyout === 1'b1) begin
      e_v = exp_q.pop_front();
      `CHK(rsp.hrdata, e_v)
      `CHK(rsp.hresp, 1'b0)
    end
    dp_rd <= bus.hsel && bus.htrans == PIF_HTRANS_NONSEQ && !bus.hwrite && rsp.hreadyout;
    cyc   <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic end_sim;
    if (exp_q.size() != 0) begin
      n_errors++;
    end
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : tick

  task automatic ahb(input logic [13:0] a, input logic w, input logic [31:0] d);
    req.htrans <= PIF_HTRANS_NONSEQ;
    req.haddr  <= a;
    req.hwrite <= w;
    req.hsize  <= PIF_HSIZE_WORD;
    req.hsel   <= 1'b1;
    do @(posedge clk_sys_i); while (rsp.hreadyout !== 1'b1);
    req.htrans <= 2'b00;
    req.hwdata <= d;
    do @(posedge clk_sys_i); while (rsp.hreadyout !== 1'b1);
  endtask : ahb

  task automatic rd(input logic [13:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    ahb(a, 1'b0, 32'h0);
  endtask : rd

  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    ahb(a, 1'b1, d);
  endtask : wr

  task automatic pulse(input logic [10:0] m);
    ev_cmd <= pif_events_t'(m);
    tick(1);
    ev_cmd <= '0;
    tick(3);
  endtask : pulse

  initial begin
    logic [31:0] wd;
    logic [7:0]  s0, s1, s2, s3;
    void'($urandom(32'h1ca66a33));
    tick(10);
    reset_n_i <= 1'b1;
    tick(1);
    for (int r = 0; r < 3; r++) rd(adr[r], {24'h0, PIF_FLAG_RESET});
    rd(A_STAT, PIF_RDATA_ZERO);
    rd(A_MASK, {24'h0, PIF_MASK_RESET});
    rd(14'h12d4, PIF_RDATA_ZERO);
    // unmasked event raises the interrupt, a masked one does not
    wr(A_MASK, 32'h2);
    pulse(11'h020);
    for (int k = 0; k < 8 && irq_o !== 1'b1; k++) tick(1);
    `CHK(irq_o, 1'b1)
    rd(A_STAT, 32'h2);
    tick(3);
    `CHK(irq_o, 1'b0)
    pulse(11'h400);
    `CHK(irq_o, 1'b0)
    rd(A_MASK, 32'h2);
    rd(A_STAT, 32'h1);
    for (int r = 0; r < 3; r++) wr(adr[r], 32'h0);
    // each event lands on its own bit, ones written never set, zero clears
    for (int i = 0; i < 11; i++) begin
      pulse(11'(1) << i);
      wr(adr[rg[i]], '1);
      rd(adr[rg[i]], 32'(8'h1 << bt[i]));
      `CHK(flo[rg[i]], 8'(8'h1 << bt[i]))
      wr(adr[rg[i]], 32'h0);
      rd(adr[rg[i]], 32'h0);
      `CHK(flo[rg[i]], 8'h00)
    end
    for (int k = 0; k < 4; k++) begin
      pulse('1);
      for (int r = 0; r < 3; r++) begin
        wd = $urandom;
        wr(adr[r], wd);
        rd(adr[r], {24'h0, wd[7:0] & sw[r]});
        wr(adr[r], 32'h0);
      end
    end
    // read-only bits mirror peripheral state and ignore writes
    for (int k = 0; k < 8; k++) begin
      s0 = ($urandom % 2) ? 8'($urandom) : 8'h0;
      s1 = ($urandom % 2) ? 8'($urandom) : 8'h0;
      s2 = ($urandom % 2) ? 8'($urandom) : 8'h0;
      s3 = ($urandom % 2) ? 8'($urandom) : 8'h0;
      wd = $urandom;
      st_cmd <= '{s0, wd[0], wd[1], s1, s2, s3, wd[2], wd[3]};
      tick(3);
      wr(adr[1], wd);
      wr(adr[2], ~wd);
      rd(adr[1], {29'h0, |s0, wd[0], wd[1]});
      rd(adr[2], {24'h0, |s1, 3'b000, |s2, |s3, wd[2], wd[3]});
      `CHK(flo[1], {5'b00000, |s0, wd[0], wd[1]})
      `CHK(flo[2], {|s1, 3'b000, |s2, |s3, wd[2], wd[3]})
    end
    // let the checker take the last read before the verdict
    tick(2);
    end_sim();
  end
endmodule : tb_peripheral_irq_flag_regs
